// ### rtl/pmc_pkg.sv
/*
 * pmc_pkg: offsets, field positions, constants and carrier types for the
 * power-management capability register block.
 * assumes: a 32-bit APB slave with byte addresses, one word per register.
 */
package pmc_pkg;

    localparam logic [7:0]  ADDR_CAP          = 8'h90;
    localparam logic [7:0]  ADDR_CSR          = 8'h94;
    localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'ha0;
    localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'ha4;
    localparam logic [7:0]  ADDR_IRQ_CLEAR    = 8'ha8;
    localparam logic [7:0]  ADDR_EVENT_SET    = 8'hac;

    // capability low half: id and next pointer, high half: capability bits
    localparam logic [7:0]  CAP_ID            = 8'h01;
    localparam logic [7:0]  CAP_NEXT_PTR      = 8'ha8;
    localparam logic [2:0]  CAP_VERSION       = 3'h2;
    localparam logic [2:0]  CAP_AUX_CURRENT   = 3'h1;
    localparam logic [4:0]  CAP_EVENT_SUPPORT = 5'h19;

    localparam int          CSR_STATE_LSB     = 0;
    localparam int          CSR_STATE_MSB     = 1;
    localparam int          CSR_EVT_EN_BIT    = 8;
    localparam int          CSR_EVT_ST_BIT    = 15;

    localparam int          IRQ_EVENT_BIT     = 0;
    localparam int          IRQ_WAKE_BIT      = 1;
    localparam int          IRQ_WIDTH         = 2;

    // reset pulse length in clk_sys cycles
    localparam int          RESET_PULSE_CYC   = 4;

    typedef enum logic [1:0] {
        PMC_D0 = 2'h0,
        PMC_D1 = 2'h1,
        PMC_D2 = 2'h2,
        PMC_D3 = 2'h3
    } pmc_pstate_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pmc_apb_req_s;

endpackage : pmc_pkg

// ### rtl/pmc_reset_pulse.sv
/*
 * pmc_reset_pulse: stretches a one-cycle trigger into an internal reset
 * pulse of fixed length.
 * assumes: trigger is synchronous to clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module pmc_reset_pulse
    import pmc_pkg::*;
#(
    parameter int PULSE_CYC = RESET_PULSE_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic trigger,
    output logic      pulseOut
);
    localparam int CW = $clog2(PULSE_CYC + 1);

    logic [CW-1:0] count_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_ff <= '0;
        end else if (trigger) begin
            count_ff <= CW'(PULSE_CYC);
        end else if (count_ff != '0) begin
            count_ff <= count_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pulseOut <= 1'b0;
        end else begin
            pulseOut <= trigger || (count_ff > CW'(1));
        end
    end
endmodule // pmc_reset_pulse
`default_nettype wire

// ### rtl/pmc_regs.sv
/*
 * pmc_regs: power-management capability, control/status and bridge
 * extension registers behind an APB slave, with power-event output,
 * internal device reset on D3->D0 and an interrupt status/enable/clear set.
 * assumes: rst is the device reset; por_n is the power-on reset that alone
 * clears the sticky bits; power_event_in is an asynchronous wake source.
 */
// What this block does
// [R1] power state field reports current state, 00 is D0, 11 is D3, resets 00
// [R2] writes of 01 or 10 to the power state are discarded
// [R3] D3 to D0 by software causes internal reset, bus reset pin untouched
// [R4] sticky event enable bit 8 gates the power-event output, resets 0
// [R5] capability version bits 18:16 read 010
// [R6] capability bit 19 reads 0, no clock needed for power events
// [R7] capability bit 21 reads 0, no special initialization
// [R8] capability bits 25 and 26 read 0, D1 and D2 unsupported
// [R9] event support bits 31:27 read 11001
// [R10] data select, data scale and data byte all read zero
// [R11] extension bits 22 and 23 read 0
// [R12] sticky event status bit 15 sets on event, clears on write 1, survives reset
// [R13] reserved bits ignore writes and read zero
`timescale 1ns/100ps
`default_nettype none
module pmc_regs
    import pmc_pkg::*;
#(
    parameter int RST_CYC = RESET_PULSE_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        por_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_event_in,
    output logic             power_event_out_n,
    output logic             internal_reset,
    output logic             pstate_d3,
    output logic             irq
);
    pmc_apb_req_s  req;
    pmc_pstate_e   pstate_ff;
    logic          evtEn_ff;
    logic          evtSt_ff;
    logic [1:0]    evtSync_ff;
    logic          evtSeen_ff;
    logic [IRQ_WIDTH-1:0] irqSt_ff;
    logic [IRQ_WIDTH-1:0] irqEn_ff;
    logic          wrEn;
    logic          rdEn;
    logic          wakeRise;
    logic          d3ToD0;
    logic          rstPulse;
    logic [31:0]   nxt_prdata;
    logic          nxt_pslverr;
    logic [1:0]    wrState;
    logic [IRQ_WIDTH-1:0] irqEvt;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    function automatic logic isMapped(input logic [7:0] a);
        return (a == ADDR_CAP) || (a == ADDR_CSR) || (a == ADDR_IRQ_STATUS) ||
               (a == ADDR_IRQ_ENABLE) || (a == ADDR_IRQ_CLEAR) || (a == ADDR_EVENT_SET);
    endfunction

    // zero wait states: access phase completes at the first enable edge
    assign wrEn    = req.psel && req.penable && req.pwrite;
    assign rdEn    = req.psel && !req.penable && !req.pwrite;
    assign wrState = req.pwdata[CSR_STATE_MSB:CSR_STATE_LSB];
    assign d3ToD0  = wrEn && (req.paddr == ADDR_CSR) && (pstate_ff == PMC_D3)
                     && (wrState == PMC_D0); // [R3]

    // event pin: first flop only feeds the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evtSync_ff <= '0;
        end else begin
            evtSync_ff <= {evtSync_ff[0], power_event_in};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evtSeen_ff <= 1'b0;
        end else begin
            evtSeen_ff <= evtSync_ff[1];
        end
    end

    // software may inject an event through the test register
    assign wakeRise = (evtSync_ff[1] && !evtSeen_ff) ||
                      (wrEn && (req.paddr == ADDR_EVENT_SET) && req.pwdata[0]);

    always_ff @(posedge clk_sys) begin
        if (rst || rstPulse) begin
            pstate_ff <= PMC_D0; // [R1]
        end else if (wrEn && (req.paddr == ADDR_CSR)) begin
            if (wrState == PMC_D0 || wrState == PMC_D3) begin
                pstate_ff <= pmc_pstate_e'(wrState); // [R1]
            end
            // D1/D2 encodings fall through untouched [R2]
        end
    end

    // sticky bits are cleared only by power-on reset, not by rst
    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            evtEn_ff <= 1'b0; // [R4]
        end else if (wrEn && (req.paddr == ADDR_CSR)) begin
            evtEn_ff <= req.pwdata[CSR_EVT_EN_BIT]; // [R4]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            evtSt_ff <= 1'b0;
        end else if (wakeRise) begin
            evtSt_ff <= 1'b1; // [R12]
        end else if (wrEn && (req.paddr == ADDR_CSR) && req.pwdata[CSR_EVT_ST_BIT]) begin
            evtSt_ff <= 1'b0; // [R12]
        end
    end

    // open-drain style active-low event line, only when enabled
    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            power_event_out_n <= 1'b1;
        end else begin
            power_event_out_n <= !(evtSt_ff && evtEn_ff); // [R4]
        end
    end

    pmc_reset_pulse #(
        .PULSE_CYC (RST_CYC)
    ) u_reset_pulse (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .trigger   (d3ToD0),
        .pulseOut  (rstPulse)
    );

    // internal reset only; the bus reset pin is never driven here [R3]
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            internal_reset <= 1'b0;
        end else begin
            internal_reset <= rstPulse; // [R3]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pstate_d3 <= 1'b0;
        end else begin
            pstate_d3 <= (pstate_ff == PMC_D3);
        end
    end

    always_comb begin
        irqEvt = '0;
        irqEvt[IRQ_EVENT_BIT] = wakeRise;
        irqEvt[IRQ_WAKE_BIT]  = d3ToD0;
    end

    // set wins over a simultaneous clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqSt_ff <= '0;
        end else if (wrEn && (req.paddr == ADDR_IRQ_CLEAR)) begin
            irqSt_ff <= (irqSt_ff & ~req.pwdata[IRQ_WIDTH-1:0]) | irqEvt;
        end else begin
            irqSt_ff <= irqSt_ff | irqEvt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqEn_ff <= '0;
        end else if (wrEn && (req.paddr == ADDR_IRQ_ENABLE)) begin
            irqEn_ff <= req.pwdata[IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqSt_ff & irqEn_ff);
        end
    end

    // read data assembled; unlisted bits stay zero [R13]
    always_comb begin
        nxt_prdata = '0;
        case (req.paddr)
            ADDR_CAP: begin
                nxt_prdata[7:0]   = CAP_ID;
                nxt_prdata[15:8]  = CAP_NEXT_PTR;
                nxt_prdata[18:16] = CAP_VERSION; // [R5]
                nxt_prdata[19]    = 1'b0; // [R6]
                nxt_prdata[21]    = 1'b0; // [R7]
                nxt_prdata[24:22] = CAP_AUX_CURRENT;
                nxt_prdata[26:25] = 2'h0; // [R8]
                nxt_prdata[31:27] = CAP_EVENT_SUPPORT; // [R9]
            end
            ADDR_CSR: begin
                nxt_prdata[CSR_STATE_MSB:CSR_STATE_LSB] = pstate_ff; // [R1]
                nxt_prdata[CSR_EVT_EN_BIT] = evtEn_ff;
                nxt_prdata[14:9]  = 6'h00; // [R10]
                nxt_prdata[CSR_EVT_ST_BIT] = evtSt_ff;
                nxt_prdata[23:22] = 2'h0; // [R11]
                nxt_prdata[31:24] = 8'h00; // [R10]
            end
            ADDR_IRQ_STATUS: begin
                nxt_prdata[IRQ_WIDTH-1:0] = irqSt_ff;
            end
            ADDR_IRQ_ENABLE: begin
                nxt_prdata[IRQ_WIDTH-1:0] = irqEn_ff;
            end
            default: begin
                nxt_prdata = '0;
            end
        endcase
    end

    assign nxt_pslverr = !isMapped(req.paddr);

    // read data captured in setup, held through access
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= '0;
        end else if (rdEn) begin
            prdata <= nxt_prdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= req.psel && !req.penable;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else if (req.psel && !req.penable) begin
            pslverr <= nxt_pslverr;
        end else begin
            pslverr <= 1'b0;
        end
    end
endmodule // pmc_regs
`default_nettype wire

// ### verification/pmc_regs_asserts.sv
/* pmc_regs_asserts: port-level checks of pmc_regs.
   assumes: bound into pmc_regs, sync active-high rst. */
`timescale 1ns/100ps
`default_nettype none
module pmc_regs_asserts
    import pmc_pkg::*;
#(
    parameter int RST_CYC = RESET_PULSE_CYC
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        por_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        power_event_in,
    input wire logic        power_event_out_n,
    input wire logic        internal_reset,
    input wire logic        pstate_d3,
    input wire logic        irq
);
    localparam int HOLD = RST_CYC - 1;
    logic rdCsr;
    logic wrCsr;
    assign rdCsr = pready && !pwrite && paddr == ADDR_CSR;
    assign wrCsr = pready && pwrite && paddr == ADDR_CSR;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || !por_n);
    setup_ack_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    ack_once_a: assert property (pready |=> !pready) else $error("pready held");
    err_pair_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    cap_value_a: assert property (pready && !pwrite && paddr == ADDR_CAP |-> prdata == 32'hc842a801)
        else $error("capability word wrong");
    csr_zero_a: assert property (rdCsr |-> (prdata & 32'hffff7efc) == 32'h0)
        else $error("reserved csr bits set");
    state_code_a: assert property (rdCsr |-> prdata[1:0] != 2'h1 && prdata[1:0] != 2'h2)
        else $error("power state shows d1 or d2");
    state_hold_a: assert property (wrCsr && (pwdata[1:0] == 2'h1 || pwdata[1:0] == 2'h2)
        |=> ##1 pstate_d3 == $past(pstate_d3, 2)) else $error("state moved on d1 or d2 write");
    wake_rst_a: assert property (wrCsr && pstate_d3 && pwdata[1:0] == 2'h0 |-> ##[1:3] internal_reset)
        else $error("no internal reset on wake");
    rst_len_a: assert property ($rose(internal_reset) |-> ##HOLD internal_reset ##1 !internal_reset)
        else $error("internal reset length wrong");
    evt_gate_a: assert property (rdCsr && !power_event_out_n |-> prdata[15] && prdata[8])
        else $error("event out without status and enable");
endmodule // pmc_regs_asserts
bind pmc_regs pmc_regs_asserts #(.RST_CYC(RST_CYC)) u_asserts (.clk_sys(clk_sys), .rst(rst), .por_n(por_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_event_in(power_event_in), .power_event_out_n(power_event_out_n),
    .internal_reset(internal_reset), .pstate_d3(pstate_d3), .irq(irq));
`default_nettype wire

// ### verification/pmc_regs_test.sv
/* pmc_regs_test: APB sequences with expected values for pmc_regs.
   assumes: 250 MHz clk_sys, zero-wait-state APB slave. */
`timescale 1ns/100ps
`default_nettype none
module pmc_regs_test
    import pmc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        por_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        evtIn = 1'b0;
    logic [31:0] rdData;
    logic        rdErr;
    logic        seen;
    wire  logic [31:0] prdata;
    wire  logic  pready, pslverr, evtOutN, intRst, d3, irq;
    int          fail_count = 0;
    int          checks_done = 0;
    pmc_regs u_dut (.clk_sys(clk_sys), .rst(rst), .por_n(por_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_event_in(evtIn), .power_event_out_n(evtOutN), .internal_reset(intRst), .pstate_d3(d3), .irq(irq));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED pready expected 1 seen %b", pready);
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rdData);
    endtask
    task automatic try_hold(input logic [31:0] e);
        for (int s = 1; s < 3; s++) begin
            xfer(1'b1, ADDR_CSR, 32'h100 | 32'(s));
            rd(ADDR_CSR, e, "state kept");
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        por_n <= 1'b1;
        rd(ADDR_CAP, 32'hc842a801, "cap");
        rd(ADDR_CSR, 32'h0, "csr reset");
        chk("event out", 32'h1, {31'h0, evtOutN});
        xfer(1'b1, ADDR_CAP, 32'hffffffff);
        rd(ADDR_CAP, 32'hc842a801, "cap written");
        xfer(1'b1, ADDR_CSR, 32'hffffffff);
        rd(ADDR_CSR, 32'h103, "csr d3");
        chk("d3 flag", 32'h1, {31'h0, d3});
        try_hold(32'h103);
        $display("test d3 entry done");
        xfer(1'b1, ADDR_CSR, 32'h100);
        seen = 1'b0;
        repeat (8) begin
            @(posedge clk_sys);
            seen |= intRst;
        end
        chk("internal reset", 32'h1, {31'h0, seen});
        rd(ADDR_CSR, 32'h100, "csr d0");
        chk("d3 flag", 32'h0, {31'h0, d3});
        try_hold(32'h100);
        rd(ADDR_IRQ_STATUS, 32'h2, "irq wake");
        chk("irq masked", 32'h0, {31'h0, irq});
        $display("test wake done");
        evtIn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(ADDR_CSR, 32'h8100, "event status");
        chk("event out", 32'h0, {31'h0, evtOutN});
        xfer(1'b1, ADDR_IRQ_ENABLE, 32'h3);
        rd(ADDR_IRQ_STATUS, 32'h3, "irq status");
        chk("irq on", 32'h1, {31'h0, irq});
        xfer(1'b1, ADDR_IRQ_CLEAR, 32'h3);
        rd(ADDR_IRQ_STATUS, 32'h0, "irq cleared");
        chk("irq off", 32'h0, {31'h0, irq});
        xfer(1'b1, ADDR_CSR, 32'h0);
        rd(ADDR_CSR, 32'h8000, "status kept");
        chk("event gated", 32'h1, {31'h0, evtOutN});
        rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ADDR_CSR, 32'h8000, "sticky status");
        xfer(1'b1, ADDR_CSR, 32'h8000);
        rd(ADDR_CSR, 32'h0, "status cleared");
        evtIn <= 1'b0;
        xfer(1'b1, ADDR_EVENT_SET, 32'h1);
        rd(ADDR_CSR, 32'h8000, "event injected");
        rd(ADDR_IRQ_STATUS, 32'h1, "irq injected");
        xfer(1'b0, 8'hb0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rdErr});
        chk("unmapped data", 32'h0, rdData);
        $display("test events done");
        print_verdict();
    end
endmodule // pmc_regs_test
`default_nettype wire
